// [pcr_pkg.sv]
// shared constants, field layout and carrier types for the capability reconfiguration bank
package pcr_pkg;

	// ----------------------------------------------------------------
	// word addresses on the reconfiguration slave port
	// ----------------------------------------------------------------
	localparam logic [7:0] PCR_ADDR_MODE = 8'h00;
	localparam logic [7:0] PCR_ADDR_LDCAP = 8'h91;
	localparam logic [7:0] PCR_ADDR_LPCAP = 8'h92;

	// ----------------------------------------------------------------
	// field positions, link/device capability word
	// ----------------------------------------------------------------
	localparam int PCR_POS_MODE = 0;
	localparam int PCR_POS_SURPRISE = 3;
	localparam int PCR_POS_DLACTIVE = 4;
	localparam int PCR_POS_EXTTAG = 5;
	localparam int PCR_POS_L0S_LO = 6;
	localparam int PCR_POS_L1_LO = 9;
	localparam int PCR_POS_IND_LO = 12;
	localparam int PCR_POS_ROLEERR = 15;

	// ----------------------------------------------------------------
	// field positions, link power capability word
	// ----------------------------------------------------------------
	localparam int PCR_POS_PWRSCALE_LO = 0;
	localparam int PCR_POS_WIDTH_LO = 2;
	localparam int PCR_POS_ASPM_LO = 8;
	localparam int PCR_POS_L1EXIT_LO = 10;

	// ----------------------------------------------------------------
	// values after reset, optional-bit mask and read latency
	// ----------------------------------------------------------------
	localparam logic PCR_RST_MODE = 1'b1;
	localparam logic [15:0] PCR_RST_LDCAP = 16'h8000;
	localparam logic [15:0] PCR_RST_LPCAP = 16'h0110;
	localparam logic [15:0] PCR_RD_ZERO = 16'h0000;
	localparam logic [15:0] PCR_OPT_MASK = 16'h0018;
	localparam int PCR_RD_LATENCY = 1;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic read;
		logic write;
		logic [7:0] address;
		logic [15:0] writedata;
	} pcr_bus_req_s;

	typedef struct packed {
		logic surprise_down;
		logic dl_active;
		logic ext_tag;
		logic [2:0] l0s_lat;
		logic [2:0] l1_lat;
		logic [2:0] ind_present;
		logic role_err;
		logic [1:0] pwr_scale;
		logic [5:0] max_width;
		logic [1:0] aspm;
		logic [5:0] l1_exit;
	} pcr_caps_s;

endpackage

// [pcr_word_store.sv]
// one 16-bit capability word with reset default and restore
module pcr_word_store
	import pcr_pkg::*;
#(
	parameter logic [15:0] RESET_VAL = 16'h0000
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// control
	input wire logic restore,
	input wire logic wr_en,
	input wire logic [15:0] wr_data,
	// stored value
	output logic [15:0] q
);

	logic [15:0] word_reg;
	logic [15:0] word_next;

	always_comb begin
		word_next = word_reg;
		if (restore) begin
			word_next = RESET_VAL;
		end else if (wr_en) begin
			word_next = wr_data;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			word_reg <= RESET_VAL;
		end else begin
			word_reg <= word_next;
		end
	end

	assign q = word_reg;

endmodule

// [pcr_cap_bank.sv]
// reprogrammable capability words behind the reconfiguration slave port
// How it works
// - surprise-down capability bit 3, default zero
// - data-link-active reporting bit 4, default zero
// - upstream or unsupported ports force both zero
// - both bits exist only for revision 1.1
// - extended tag support bit 5, default zero
// - bits 8:6 L0s acceptable latency code
// - bits 11:9 L1 acceptable latency code
// - bits 14:12 button and indicator presence
// - scale 1:0 and link width 7:2
// - bits 9:8 ASPM support, default 01
// - bits 15:10 L1 exit latencies
// - mode bit 0: one restores image values
module pcr_cap_bank
	import pcr_pkg::*;
#(
	parameter bit PORT_IS_DOWNSTREAM = 1'b1,
	parameter bit BASE_REV_1P1 = 1'b1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// reconfiguration slave port
	input wire pcr_bus_req_s bus_req,
	output logic [15:0] readdata,
	output logic readdatavalid,
	// towards the link layer
	output pcr_caps_s caps,
	output logic reconfig_active
);

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	// optional reporting bits gated
	localparam bit OPT_ALLOWED = PORT_IS_DOWNSTREAM && BASE_REV_1P1;

	function automatic logic [15:0] mask_opt(input logic [15:0] w);
		mask_opt = OPT_ALLOWED ? w : (w & ~PCR_OPT_MASK);
	endfunction

	function automatic pcr_caps_s words_to_caps(input logic [15:0] w1, input logic [15:0] w2);
		pcr_caps_s c;
		c.surprise_down = w1[PCR_POS_SURPRISE];
		c.dl_active = w1[PCR_POS_DLACTIVE];
		c.ext_tag = w1[PCR_POS_EXTTAG];
		c.l0s_lat = w1[PCR_POS_L0S_LO +: 3];
		c.l1_lat = w1[PCR_POS_L1_LO +: 3];
		c.ind_present = w1[PCR_POS_IND_LO +: 3];
		c.role_err = w1[PCR_POS_ROLEERR];
		c.pwr_scale = w2[PCR_POS_PWRSCALE_LO +: 2];
		c.max_width = w2[PCR_POS_WIDTH_LO +: 6];
		c.aspm = w2[PCR_POS_ASPM_LO +: 2];
		c.l1_exit = w2[PCR_POS_L1EXIT_LO +: 6];
		words_to_caps = c;
	endfunction

	localparam logic [1:0][15:0] WORD_DEFAULTS = {PCR_RST_LPCAP, mask_opt(PCR_RST_LDCAP)};
	localparam logic [1:0][7:0] WORD_ADDRS = {PCR_ADDR_LPCAP, PCR_ADDR_LDCAP};
	localparam pcr_caps_s CAPS_DEFAULT = words_to_caps(mask_opt(PCR_RST_LDCAP), PCR_RST_LPCAP);

	// ----------------------------------------------------------------
	// mode bit
	// ----------------------------------------------------------------
	logic mode_reg;
	logic mode_next;
	logic mode_wr;
	logic restore;

	assign mode_wr = bus_req.write && (bus_req.address == PCR_ADDR_MODE);
	// setting the bit reloads image values
	assign restore = mode_wr && bus_req.writedata[PCR_POS_MODE];

	always_comb begin
		mode_next = mode_reg;
		if (mode_wr) begin
			mode_next = bus_req.writedata[PCR_POS_MODE];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			mode_reg <= PCR_RST_MODE;
		end else begin
			mode_reg <= mode_next;
		end
	end

	// ----------------------------------------------------------------
	// capability word stores
	// ----------------------------------------------------------------
	logic [1:0][15:0] store_q;
	logic [1:0][15:0] eff_word;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_word
			logic wr_en;
			assign wr_en = bus_req.write && !mode_reg && (bus_req.address == WORD_ADDRS[gi]);
			pcr_word_store #(
				.RESET_VAL(WORD_DEFAULTS[gi])
			) u_store (
				.clk(clk),
				.rst(rst),
				.restore(restore),
				.wr_en(wr_en),
				.wr_data(gi == 0 ? mask_opt(bus_req.writedata) : bus_req.writedata),
				.q(store_q[gi])
			);
			assign eff_word[gi] = mode_reg ? WORD_DEFAULTS[gi] : store_q[gi];
		end
	endgenerate

	// ----------------------------------------------------------------
	// outputs and read path
	// ----------------------------------------------------------------
	pcr_caps_s caps_reg;
	pcr_caps_s caps_next;
	logic [15:0] rdata_reg;
	logic [15:0] rdata_next;
	logic rvalid_reg;
	logic rvalid_next;
	logic active_reg;
	logic active_next;

	always_comb begin
		caps_next = words_to_caps(mask_opt(eff_word[0]), eff_word[1]);
		active_next = !mode_reg;
		rvalid_next = bus_req.read;
		rdata_next = PCR_RD_ZERO;
		if (bus_req.read) begin
			case (bus_req.address)
				PCR_ADDR_MODE: begin
					rdata_next = {15'h0000, mode_reg};
				end
				PCR_ADDR_LDCAP: begin
					rdata_next = mask_opt(eff_word[0]);
				end
				PCR_ADDR_LPCAP: begin
					rdata_next = eff_word[1];
				end
				default: begin
					rdata_next = PCR_RD_ZERO;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			caps_reg <= CAPS_DEFAULT;
			rdata_reg <= PCR_RD_ZERO;
			rvalid_reg <= 1'b0;
			active_reg <= 1'b0;
		end else begin
			caps_reg <= caps_next;
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
			active_reg <= active_next;
		end
	end

	assign caps = caps_reg;
	assign readdata = rdata_reg;
	assign readdatavalid = rvalid_reg;
	assign reconfig_active = active_reg;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence s_ld_write;
		bus_req.write && !mode_reg && bus_req.address == PCR_ADDR_LDCAP;
	endsequence

	sequence s_lp_write;
		bus_req.write && !mode_reg && bus_req.address == PCR_ADDR_LPCAP;
	endsequence

	sequence s_locked_write;
		bus_req.write && mode_reg && bus_req.address != PCR_ADDR_MODE;
	endsequence

	sequence s_restore;
		bus_req.write && bus_req.address == PCR_ADDR_MODE && bus_req.writedata[PCR_POS_MODE];
	endsequence

	sequence s_mode_clear;
		bus_req.write && bus_req.address == PCR_ADDR_MODE && !bus_req.writedata[PCR_POS_MODE];
	endsequence

	sequence s_ld_read;
		bus_req.read && bus_req.address == PCR_ADDR_LDCAP;
	endsequence

	sequence s_lp_read;
		bus_req.read && bus_req.address == PCR_ADDR_LPCAP;
	endsequence

	a_surprise_bit: assert property (s_ld_write ##0 OPT_ALLOWED |->
		##2 caps_reg.surprise_down == $past(bus_req.writedata[3], 2))
		else $error("surprise-down bit not taken from write");
	a_dlactive_bit: assert property (s_ld_write ##0 OPT_ALLOWED |->
		##2 caps_reg.dl_active == $past(bus_req.writedata[4], 2))
		else $error("data-link-active bit not taken from write");
	a_opt_forced_zero: assert property (!OPT_ALLOWED |-> !caps_reg.surprise_down && !caps_reg.dl_active)
		else $error("optional reporting bits set on gated port");
	a_rev_read_gate: assert property (rvalid_reg && $past(bus_req.address) == PCR_ADDR_LDCAP && !OPT_ALLOWED
		|-> readdata[4:3] == 2'b00)
		else $error("optional bits readable without revision support");
	a_devcap_fields: assert property (s_ld_write |->
		##2 (caps_reg.ext_tag == $past(bus_req.writedata[5], 2)
		&& caps_reg.l0s_lat == $past(bus_req.writedata[8:6], 2)))
		else $error("extended tag or L0s latency not updated");
	a_l1_latency: assert property (s_ld_write |-> ##2 caps_reg.l1_lat == $past(bus_req.writedata[11:9], 2))
		else $error("L1 latency field not updated");
	a_indicators: assert property (s_ld_write |->
		##2 caps_reg.ind_present == $past(bus_req.writedata[14:12], 2))
		else $error("indicator presence field not updated");
	a_power_word: assert property (s_lp_write |->
		##2 {caps_reg.l1_exit, caps_reg.aspm, caps_reg.max_width, caps_reg.pwr_scale} == $past(bus_req.writedata, 2))
		else $error("power capability word not updated");
	a_mode_restore: assert property ($past(mode_reg) |-> caps_reg == CAPS_DEFAULT)
		else $error("image values not presented while disabled");
	a_reset_defaults: assert property ($past(rst) |-> caps_reg == CAPS_DEFAULT && !rvalid_reg)
		else $error("defaults not presented after reset");
	a_read_mode: assert property (bus_req.read && bus_req.address == PCR_ADDR_MODE |=>
		rvalid_reg && readdata == {15'h0000, $past(mode_reg)})
		else $error("mode read wrong or late");

	// ----------------------------------------------------------------
	// checks, field updates, mode and read path
	// ----------------------------------------------------------------
	// L0s code lands
	a_l0s_latency: assert property (s_ld_write |-> ##2 caps_reg.l0s_lat == $past(bus_req.writedata[8:6], 2))
		else $error("L0s latency field not updated");
	a_scale_width: assert property (s_lp_write |->
		##2 (caps_reg.pwr_scale == $past(bus_req.writedata[1:0], 2)
		&& caps_reg.max_width == $past(bus_req.writedata[7:2], 2)))
		else $error("power scale or link width not updated");
	a_aspm_field: assert property (s_lp_write |-> ##2 caps_reg.aspm == $past(bus_req.writedata[9:8], 2))
		else $error("ASPM support field not updated");
	a_exit_latency: assert property (s_lp_write |->
		##2 caps_reg.l1_exit == $past(bus_req.writedata[15:10], 2))
		else $error("L1 exit latency field not updated");
	a_locked_ignore: assert property (s_locked_write |=> store_q == $past(store_q))
		else $error("stored word changed while reprogramming disabled");
	a_restore_reload: assert property (s_restore |=>
		store_q[0] == WORD_DEFAULTS[0] && store_q[1] == WORD_DEFAULTS[1])
		else $error("stores not reloaded on restore");
	a_restore_caps: assert property (s_restore |-> ##2 caps_reg == CAPS_DEFAULT)
		else $error("image values not shown after restore");
	a_mode_clear: assert property (s_mode_clear |-> ##2 reconfig_active)
		else $error("reprogramming not flagged after mode clear");
	a_active_follow: assert property (!$past(rst) |-> reconfig_active == !$past(mode_reg))
		else $error("reconfig flag does not follow mode");
	a_read_valid: assert property (!$past(rst) |-> readdatavalid == $past(bus_req.read))
		else $error("read valid does not follow read strobe");
	a_ld_read_locked: assert property (s_ld_read ##0 mode_reg |=> readdata == WORD_DEFAULTS[0])
		else $error("first word read not image value while disabled");
	a_lp_read_locked: assert property (s_lp_read ##0 mode_reg |=> readdata == WORD_DEFAULTS[1])
		else $error("second word read not image value while disabled");
	a_opt_store_zero: assert property (!OPT_ALLOWED |-> store_q[0][PCR_POS_SURPRISE] == 1'b0
		&& store_q[0][PCR_POS_DLACTIVE] == 1'b0)
		else $error("optional reporting bits stored on gated port");

endmodule

// [tb_top.sv]
// self-checking bench for the capability reconfiguration bank
module tb_top
	import pcr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	// ----------------------------------------------------------------
	// clock, reset and the three configurations under test
	// ----------------------------------------------------------------
	logic clk = 1'b0;
	logic rst = 1'b1;
	pcr_bus_req_s bus_req = '0;
	logic [15:0] readdata;
	logic [15:0] rd_up;
	logic [15:0] rd_old;
	logic readdatavalid;
	logic reconfig_active;
	pcr_caps_s caps;
	pcr_caps_s caps_up;
	pcr_caps_s caps_old;
	int n_errors = 0;
	int compares = 0;
	int cycles = 0;
	logic [15:0] pat1 [4] = '{16'hffff, 16'h0000, 16'h6db0, 16'ha5a8};
	logic [15:0] pat2 [4] = '{16'hffff, 16'h0000, 16'ha5a5, 16'h5a5a};

	always #25 clk = ~clk;

	pcr_cap_bank i_pcr_cap_bank (.clk(clk), .rst(rst), .bus_req(bus_req), .readdata(readdata),
		.readdatavalid(readdatavalid), .caps(caps), .reconfig_active(reconfig_active));
	// upstream port and older revision both lose the optional bits
	pcr_cap_bank #(.PORT_IS_DOWNSTREAM(1'b0)) i_pcr_cap_bank_up (.clk(clk), .rst(rst), .bus_req(bus_req),
		.readdata(rd_up), .readdatavalid(), .caps(caps_up), .reconfig_active());
	pcr_cap_bank #(.BASE_REV_1P1(1'b0)) i_pcr_cap_bank_old (.clk(clk), .rst(rst), .bus_req(bus_req),
		.readdata(rd_old), .readdatavalid(), .caps(caps_old), .reconfig_active());

	// ----------------------------------------------------------------
	// checking and access tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	function automatic pcr_caps_s fields(input logic [15:0] w1, input logic [15:0] w2);
		return {w1[3], w1[4], w1[5], w1[8:6], w1[11:9], w1[14:12], w1[15], w2[1:0], w2[7:2], w2[9:8], w2[15:10]};
	endfunction

	task automatic wr(input logic [7:0] addr, input logic [15:0] data);
		@(negedge clk);
		bus_req.write = 1'b1;
		bus_req.address = addr;
		bus_req.writedata = data;
		@(negedge clk);
		bus_req.write = 1'b0;
	endtask

	// optional bits 3 and 4 read zero on the two reduced instances
	task automatic rd(input logic [7:0] addr, input logic [15:0] exp);
		logic [15:0] exp_opt;
		exp_opt = (addr == 8'h91) ? (exp & 16'hffe7) : exp;
		@(negedge clk);
		bus_req.read = 1'b1;
		bus_req.address = addr;
		@(negedge clk);
		bus_req.read = 1'b0;
		chk(readdatavalid, 1'b1, "read valid");
		chk(readdata, exp, "read data");
		chk(rd_up, exp_opt, "upstream read data");
		chk(rd_old, exp_opt, "older revision read data");
	endtask

	// caps lag a write by two edges, so look one cycle after the write ends
	task automatic caps_chk(input logic [15:0] w1, input logic [15:0] w2, input logic act);
		@(negedge clk);
		chk(caps, fields(w1, w2), "caps");
		chk(caps_up, fields(w1 & 16'hffe7, w2), "upstream caps");
		chk(caps_old, fields(w1 & 16'hffe7, w2), "older revision caps");
		chk(reconfig_active, act, "reconfig active");
		chk(readdatavalid, 1'b0, "idle read valid");
		chk(readdata, 16'h0000, "idle read data");
	endtask

	task automatic stop_test();
		$display("compares %0d, errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		repeat (3) @(negedge clk);
		rst = 1'b0;
		caps_chk(16'h8000, 16'h0110, 1'b0);
		rd(8'h00, 16'h0001);
		rd(8'h91, 16'h8000);
		rd(8'h92, 16'h0110);
		rd(8'h50, 16'h0000);
		$display("test defaults done");
		wr(8'h91, 16'h7fff);
		wr(8'h92, 16'hfeef);
		rd(8'h91, 16'h8000);
		rd(8'h92, 16'h0110);
		caps_chk(16'h8000, 16'h0110, 1'b0);
		$display("test locked done");
		// words rewritten only while reprogramming is open
		wr(8'h00, 16'h0000);
		caps_chk(16'h8000, 16'h0110, 1'b1);
		// all-ones codes and mixed optional bits
		for (int i = 0; i < 4; i++) begin
			wr(8'h91, pat1[i]);
			wr(8'h92, pat2[i]);
			caps_chk(pat1[i], pat2[i], 1'b1);
			rd(8'h91, pat1[i]);
			rd(8'h92, pat2[i]);
		end
		wr(8'h93, 16'hffff);
		rd(8'h93, 16'h0000);
		wr(8'h00, 16'hfffe);
		rd(8'h00, 16'h0000);
		$display("test reprogram done");
		// setting the mode bit restores the image values
		wr(8'h00, 16'h0001);
		caps_chk(16'h8000, 16'h0110, 1'b0);
		rd(8'h91, 16'h8000);
		wr(8'h00, 16'h0000);
		caps_chk(16'h8000, 16'h0110, 1'b1);
		rd(8'h92, 16'h0110);
		$display("test restore done");
		// a reset in mid-run drops programmed words
		wr(8'h91, 16'h7fff);
		rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		caps_chk(16'h8000, 16'h0110, 1'b0);
		wr(8'h00, 16'h0000);
		caps_chk(16'h8000, 16'h0110, 1'b1);
		rd(8'h91, 16'h8000);
		$display("test reset done");
		stop_test();
	end

	// run needs under a hundred cycles; a hang is cut off well beyond that
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			n_errors++;
			stop_test();
		end
	end
endmodule
